/* File: logic/lmi_i2c_slave.v */
/*
 * two-wire serial slave giving a host access to the internal registers:
 * start/stop detection, address match, index with auto-increment,
 * write commit on the acknowledge of each data byte and read-back.
 * assumes the clock and data pins are open drain with external pull-ups and
 * an SCL rate far below the 100 MHz system clock (400 kHz at most).
 */
`timescale 1ns/1ps
`include "lmi_regs.vh"

// Function
// - data is sampled on rising clock; the device changes data only while clock is low
// - data toggling with clock high mid-transfer abandons it and drops partial byte
// - data falling while clock high is a start
// - data rising while clock high is a stop
// - bus counts as busy from start until the next stop
// - a repeated start behaves like a first start and restarts address reception
// - bytes are eight bits, most significant bit first
// - transmitter releases data during acknowledge; receiver drives low on ninth pulse
// - once addressed, every received byte is acknowledged
// - first byte is seven address bits then direction, zero write, one read
// - answer address 54h with strap low, 55h with strap high, nothing else
// - in a write, second byte is register index, third byte is data
// - written value takes effect on rising clock of the final acknowledge
// - index auto-increments after each byte written and after each read byte the master acknowledges
module lmi_i2c_slave (
    // clock and reset
    input  wire       clk_sys,
    input  wire       reset_n,
    // serial pins, data is open drain
    input  wire       sclPin,
    input  wire       sdaPin,
    output reg        sdaOut_ff,
    output reg        sdaOe_ff,
    // address strap
    input  wire       addrSelPin,
    // status
    output reg        busBusy_ff,
    // register update notice
    output reg        regWrStrobe_ff,
    output reg  [7:0] regWrIndex_ff,
    output reg  [7:0] regWrData_ff,
    // device read of the register store
    input  wire [7:0] cfgRdIndex,
    output wire [7:0] cfgRdData
);

    // protocol states
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_RX   = 3'h1;
    localparam [2:0] ST_ACK  = 3'h2;
    localparam [2:0] ST_TX   = 3'h3;
    localparam [2:0] ST_MACK = 3'h4;
    localparam [2:0] ST_SKIP = 3'h5;

    // kind of byte being received
    localparam [1:0] BK_ADDR  = 2'h0;
    localparam [1:0] BK_INDEX = 2'h1;
    localparam [1:0] BK_DATA  = 2'h2;

    localparam integer HOLD_CYC = `LMI_HOLD_CYC;
    localparam [6:0]   HOLD_LD  = HOLD_CYC[6:0];

    wire [2:0] pinSync;
    wire       sclS;
    wire       sdaS;
    wire       addrSelS;
    wire [7:0] rdData;

    reg  [2:0] state_ff;
    reg  [3:0] bitCnt_ff;
    reg  [7:0] shift_ff;
    reg  [1:0] byteKind_ff;
    reg  [1:0] ackKind_ff;
    reg        readMode_ff;
    reg        masterAck_ff;
    reg  [7:0] index_ff;
    reg  [6:0] holdCnt_ff;
    reg        pendLow_ff;
    reg        sclD_ff;
    reg        sdaD_ff;

    wire       sclRise;
    wire       sclFall;
    wire       startSeen;
    wire       stopSeen;
    wire [6:0] myAddr;

    // pins pass two flip-flops before any logic looks at them
    lmi_sync2 #(
        .W (3)
    ) u_sync (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .asyncIn ({addrSelPin, sdaPin, sclPin}),
        .syncOut (pinSync)
    );

    assign sclS     = pinSync[0];
    assign sdaS     = pinSync[1];
    assign addrSelS = pinSync[2];

    lmi_reg_store u_store (
        .clk_sys    (clk_sys),
        .reset_n    (reset_n),
        .wrEn       (regWrStrobe_ff),
        .wrIndex    (regWrIndex_ff),
        .wrData     (regWrData_ff),
        .rdIndexA   (index_ff),
        .rdDataA    (rdData),
        .rdIndexB   (cfgRdIndex),
        .rdDataB_ff (cfgRdData)
    );

    // edge and condition detection on the synchronised levels
    assign sclRise   = sclS & ~sclD_ff;
    assign sclFall   = ~sclS & sclD_ff;
    assign startSeen = sclS & sclD_ff & sdaD_ff & ~sdaS;
    assign stopSeen  = sclS & sclD_ff & ~sdaD_ff & sdaS;

    // strap picks one of two addresses
    assign myAddr = addrSelS ? `LMI_ADDR_SEL_HIGH : `LMI_ADDR_SEL_LOW;

    // delayed copies for edge detection
    always @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sclD_ff <= 1'b1;
            sdaD_ff <= 1'b1;
        end
        else
        begin
            sclD_ff <= sclS;
            sdaD_ff <= sdaS;
        end
    end

    // protocol engine; data changes are scheduled from the falling clock edge
    // and applied after the hold count, so they land while clock is low
    always @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_ff       <= ST_IDLE;
            bitCnt_ff      <= 4'h0;
            shift_ff       <= 8'h00;
            byteKind_ff    <= BK_ADDR;
            ackKind_ff     <= BK_ADDR;
            readMode_ff    <= 1'b0;
            masterAck_ff   <= 1'b0;
            index_ff       <= 8'h00;
            holdCnt_ff     <= 7'h00;
            pendLow_ff     <= 1'b0;
            sdaOut_ff      <= 1'b0;
            sdaOe_ff       <= 1'b0;
            busBusy_ff     <= 1'b0;
            regWrStrobe_ff <= 1'b0;
            regWrIndex_ff  <= 8'h00;
            regWrData_ff   <= 8'h00;
        end
        else
        begin
            // open drain: the pin is only ever pulled low, never driven high
            sdaOut_ff      <= 1'b0;
            regWrStrobe_ff <= 1'b0;

            // scheduled data change after the hold time
            if (holdCnt_ff != 7'h00)
            begin
                holdCnt_ff <= holdCnt_ff - 7'h01;
                if (holdCnt_ff == 7'h01)
                    sdaOe_ff <= pendLow_ff;
            end

            if (startSeen)
            begin
                // first or repeated start alike; partial byte dropped
                state_ff    <= ST_RX;
                bitCnt_ff   <= 4'h0;
                shift_ff    <= 8'h00;
                byteKind_ff <= BK_ADDR;
                holdCnt_ff  <= 7'h00;
                sdaOe_ff    <= 1'b0;
                busBusy_ff  <= 1'b1;
            end
            else if (stopSeen)
            begin
                // a stop mid-byte also abandons the transfer
                state_ff   <= ST_IDLE;
                bitCnt_ff  <= 4'h0;
                holdCnt_ff <= 7'h00;
                sdaOe_ff   <= 1'b0;
                busBusy_ff <= 1'b0;
            end
            else
            begin
                case (state_ff)
                    ST_RX:
                    begin
                        if (sclRise)
                        begin
                            shift_ff  <= {shift_ff[6:0], sdaS};
                            bitCnt_ff <= bitCnt_ff + 4'h1;
                        end
                        if (sclFall && bitCnt_ff == `LMI_BITS_PER_BYTE)
                        begin
                            bitCnt_ff  <= 4'h0;
                            ackKind_ff <= byteKind_ff;
                            pendLow_ff <= 1'b1;
                            holdCnt_ff <= HOLD_LD;
                            state_ff   <= ST_ACK;
                            case (byteKind_ff)
                                BK_ADDR:
                                begin
                                    if (shift_ff[7:1] == myAddr)
                                    begin
                                        readMode_ff <= shift_ff[`LMI_DIR_BIT]
                                                       == `LMI_DIR_READ;
                                        byteKind_ff <= BK_INDEX;
                                    end
                                    else
                                    begin
                                        pendLow_ff <= 1'b0;
                                        holdCnt_ff <= 7'h00;
                                        state_ff   <= ST_SKIP;
                                    end
                                end
                                BK_INDEX:
                                begin
                                    index_ff    <= shift_ff;
                                    byteKind_ff <= BK_DATA;
                                end
                                default:
                                begin
                                    byteKind_ff <= BK_DATA;
                                end
                            endcase
                        end
                    end
                    ST_ACK:
                    begin
                        // commit lands on the rising edge of the ack pulse
                        if (sclRise && ackKind_ff == BK_DATA)
                        begin
                            regWrStrobe_ff <= 1'b1;
                            regWrIndex_ff  <= index_ff;
                            regWrData_ff   <= shift_ff;
                            index_ff       <= index_ff + 8'h01;
                        end
                        if (sclFall)
                        begin
                            holdCnt_ff <= HOLD_LD;
                            bitCnt_ff  <= 4'h0;
                            if (readMode_ff && ackKind_ff == BK_ADDR)
                            begin
                                shift_ff   <= rdData;
                                pendLow_ff <= ~rdData[7];
                                state_ff   <= ST_TX;
                            end
                            else
                            begin
                                pendLow_ff <= 1'b0;
                                state_ff   <= ST_RX;
                            end
                        end
                    end
                    ST_TX:
                    begin
                        if (sclRise)
                            bitCnt_ff <= bitCnt_ff + 4'h1;
                        if (sclFall)
                        begin
                            holdCnt_ff <= HOLD_LD;
                            if (bitCnt_ff == `LMI_BITS_PER_BYTE)
                            begin
                                // transmitter releases for the master's ack
                                pendLow_ff <= 1'b0;
                                state_ff   <= ST_MACK;
                            end
                            else
                            begin
                                shift_ff   <= {shift_ff[6:0], 1'b0};
                                pendLow_ff <= ~shift_ff[6];
                            end
                        end
                    end
                    ST_MACK:
                    begin
                        if (sclRise)
                        begin
                            masterAck_ff <= ~sdaS;
                            if (!sdaS)
                                index_ff <= index_ff + 8'h01;
                        end
                        if (sclFall)
                        begin
                            bitCnt_ff <= 4'h0;
                            if (masterAck_ff)
                            begin
                                shift_ff   <= rdData;
                                pendLow_ff <= ~rdData[7];
                                holdCnt_ff <= HOLD_LD;
                                state_ff   <= ST_TX;
                            end
                            else
                            begin
                                state_ff <= ST_SKIP;
                            end
                        end
                    end
                    ST_SKIP:
                    begin
                        // released; only a start or stop gets us out
                        sdaOe_ff <= 1'b0;
                    end
                    ST_IDLE:
                    begin
                        sdaOe_ff <= 1'b0;
                    end
                    default:
                    begin
                        state_ff <= ST_IDLE;
                    end
                endcase
            end
        end
    end

endmodule

/* File: logic/lmi_regs.vh */
/*
 * constants of the two-wire register access slave: bus addresses,
 * byte layout and the output data hold timing.
 * assumes the includer runs on a 100 MHz system clock.
 */
`ifndef LMI_REGS_VH
`define LMI_REGS_VH

// bus addresses selected by the strap input
`define LMI_ADDR_SEL_LOW     7'h54
`define LMI_ADDR_SEL_HIGH    7'h55

// byte layout
`define LMI_BITS_PER_BYTE    4'h8
`define LMI_DIR_BIT          0
`define LMI_DIR_READ         1'b1

// register store
`define LMI_INDEX_W          8
`define LMI_DEPTH            256
`define LMI_DATA_RESET       8'h00

// timing: data hold after the falling clock edge, least 300 ns
`define LMI_CLK_MHZ          100
`define LMI_T_HOLD_NS        300
`define LMI_HOLD_CYC         ((`LMI_T_HOLD_NS * `LMI_CLK_MHZ + 999) / 1000)

`endif

/* File: logic/lmi_sync2.v */
/*
 * two flip-flop synchroniser for a group of asynchronous pin levels.
 * assumes the inputs are levels; nothing but the second stage reads stage one.
 */
`timescale 1ns/1ps

module lmi_sync2 #(
    parameter W = 1
) (
    // clock and reset
    input  wire         clk_sys,
    input  wire         reset_n,
    // levels
    input  wire [W-1:0] asyncIn,
    output wire [W-1:0] syncOut
);

    reg [W-1:0] meta_ff;
    reg [W-1:0] stable_ff;

    // reset high: an idle two-wire bus is pulled up
    always @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            meta_ff   <= {W{1'b1}};
            stable_ff <= {W{1'b1}};
        end
        else
        begin
            meta_ff   <= asyncIn;
            stable_ff <= meta_ff;
        end
    end

    assign syncOut = stable_ff;

endmodule

/* File: logic/lmi_reg_store.v */
/*
 * internal register store written and read through the serial slave.
 * assumes one write port from the slave, one combinational read for the
 * slave and one registered read port for the device's own logic.
 */
`timescale 1ns/1ps
`include "lmi_regs.vh"

module lmi_reg_store (
    // clock and reset
    input  wire       clk_sys,
    input  wire       reset_n,
    // write port
    input  wire       wrEn,
    input  wire [7:0] wrIndex,
    input  wire [7:0] wrData,
    // serial read port
    input  wire [7:0] rdIndexA,
    output wire [7:0] rdDataA,
    // device read port
    input  wire [7:0] rdIndexB,
    output reg  [7:0] rdDataB_ff
);

    reg [7:0] mem [0:`LMI_DEPTH-1];
    integer   i;

    // store updates only on the write strobe, so a value lands as one step
    always @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            for (i = 0; i < `LMI_DEPTH; i = i + 1)
                mem[i] <= `LMI_DATA_RESET;
            rdDataB_ff <= `LMI_DATA_RESET;
        end
        else
        begin
            if (wrEn)
                mem[wrIndex] <= wrData;
            rdDataB_ff <= mem[rdIndexB];
        end
    end

    assign rdDataA = mem[rdIndexA];

endmodule

/* File: verif/lmi_i2c_slave_assertions.sv */
/*
 * checker of the serial register slave: pin timing, bus state, write notice.
 * assumes it is bound to lmi_i2c_slave running on a 100 MHz clock.
 */
`timescale 1ns/1ps

module lmi_i2c_slave_chk (
    // clock and reset
    input wire       clk_sys,
    input wire       reset_n,
    // serial pins and strap
    input wire       sclPin,
    input wire       sdaPin,
    input wire       sdaOut_ff,
    input wire       sdaOe_ff,
    input wire       addrSelPin,
    // status and write notice
    input wire       busBusy_ff,
    input wire       regWrStrobe_ff,
    input wire [7:0] regWrIndex_ff,
    input wire [7:0] regWrData_ff,
    // device read port
    input wire [7:0] cfgRdIndex,
    input wire [7:0] cfgRdData
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    // conditions held a few cycles so the synchroniser delay cannot hide them
    sequence startSeen;
        sclPin && $fell(sdaPin) ##1 sclPin [*3];
    endsequence
    sequence stopSeen;
        sclPin && $rose(sdaPin) ##1 sclPin [*3];
    endsequence

    AST_OPEN_DRAIN: assert property (sdaOe_ff |-> !sdaOut_ff)
        else $error("data pin driven high");
    AST_START_BUSY: assert property (startSeen |-> ##[1:5] busBusy_ff)
        else $error("start not seen");
    AST_STOP_FREE: assert property (stopSeen |-> ##[1:5] !busBusy_ff)
        else $error("stop not seen");
    AST_BUSY_SET: assert property ($rose(busBusy_ff) |-> sclPin && !sdaPin)
        else $error("busy set without start");
    AST_BUSY_CLR: assert property ($fell(busBusy_ff) |-> sclPin && sdaPin)
        else $error("busy cleared without stop");
    AST_IDLE_RELEASED: assert property (!busBusy_ff && !$past(busBusy_ff) |-> !sdaOe_ff)
        else $error("data pulled on idle bus");
    // a pull may only move well into a low clock phase, after the hold time
    AST_DRIVE_SCL_LOW: assert property ($changed(sdaOe_ff) |-> !sclPin && !$past(sclPin, 30))
        else $error("data drive changed at wrong time");
    AST_STROBE_PULSE: assert property (regWrStrobe_ff |=> !regWrStrobe_ff)
        else $error("write notice longer than one cycle");
    AST_STROBE_AT_ACK: assert property (regWrStrobe_ff |-> sclPin && sdaOe_ff && !$past(sclPin, 8))
        else $error("write not at acknowledge rise");
    AST_STORE_UPDATE: assert property (regWrStrobe_ff ##1 (cfgRdIndex == regWrIndex_ff) [*2]
        |-> cfgRdData == regWrData_ff)
        else $error("store not updated");
endmodule

bind lmi_i2c_slave lmi_i2c_slave_chk i_lmi_i2c_slave_chk (
    .clk_sys(clk_sys), .reset_n(reset_n), .sclPin(sclPin), .sdaPin(sdaPin),
    .sdaOut_ff(sdaOut_ff), .sdaOe_ff(sdaOe_ff), .addrSelPin(addrSelPin),
    .busBusy_ff(busBusy_ff), .regWrStrobe_ff(regWrStrobe_ff),
    .regWrIndex_ff(regWrIndex_ff), .regWrData_ff(regWrData_ff),
    .cfgRdIndex(cfgRdIndex), .cfgRdData(cfgRdData));

/* File: verif/lmi_host_model.sv */
/*
 * behavioural two-wire bus master used as the host of the slave.
 * assumes open-drain lines with pull-ups: an output of 1 means released.
 */
`timescale 1ns/1ps

module lmi_host_model #(
    parameter int HALF = 125
) (
    // clock used for pacing only
    input wire  clk_sys,
    // wired data level
    input wire  sdaBus,
    // master drive
    output logic sclM,
    output logic sdaM
);
    // idle bus at time zero
    initial
    begin
        sclM = 1'b1;
        sdaM = 1'b1;
    end

    task automatic wait_q(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // first or repeated start: data falls while clock high
    task automatic start_cond();
        wait_q(HALF / 2);
        sdaM = 1'b1;
        wait_q(HALF / 2);
        sclM = 1'b1;
        wait_q(HALF);
        sdaM = 1'b0;
        wait_q(HALF);
        sclM = 1'b0;
    endtask

    // stop: data rises while clock high
    task automatic stop_cond();
        wait_q(HALF / 2);
        sdaM = 1'b0;
        wait_q(HALF / 2);
        sclM = 1'b1;
        wait_q(HALF);
        sdaM = 1'b1;
        wait_q(HALF);
    endtask

    // one clock pulse; data moves mid low phase, sampled at end of high
    task automatic bit_io(input logic b, output logic r);
        wait_q(HALF / 2);
        sdaM = b;
        wait_q(HALF / 2);
        sclM = 1'b1;
        wait_q(HALF - 2);
        r = sdaBus;
        wait_q(2);
        sclM = 1'b0;
    endtask

    // msb first, then release for the slave's acknowledge
    task automatic wr_byte(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(v[i], r);
        bit_io(1'b1, ack);
    endtask

    // released while the slave sends, then our own acknowledge
    task automatic rd_byte(input logic ackBit, output logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, v[i]);
        bit_io(ackBit, r);
    endtask
endmodule

/* File: verif/tb_top.sv */
/*
 * self-checking bench of the two-wire register slave.
 * assumes lmi_host_model as bus master with a 2.5 us serial clock period.
 */
`timescale 1ns/1ps

`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb_top;
    logic       clk_sys = 1'b0;
    logic       reset_n = 1'b0;
    logic       addrSelPin = 1'b0;
    logic [7:0] cfgRdIndex = 8'h00;
    wire        sclM, sdaM, sdaOut, sdaOe, busBusy, wrStb;
    wire  [7:0] wrIdx, wrDat, cfgRdData;
    int         err_total = 0;
    int         check_count = 0;
    int         stbCount = 0;
    // wired-and bus with pull-up; the slave only ever pulls low
    wire        sdaBus = sdaM & ~sdaOe;

    always #5 clk_sys = ~clk_sys;

    // count committed writes
    always @(posedge clk_sys)
        if (wrStb === 1'b1)
            stbCount++;

    lmi_i2c_slave i_lmi_i2c_slave (.clk_sys(clk_sys), .reset_n(reset_n), .sclPin(sclM),
        .sdaPin(sdaBus), .sdaOut_ff(sdaOut), .sdaOe_ff(sdaOe), .addrSelPin(addrSelPin),
        .busBusy_ff(busBusy), .regWrStrobe_ff(wrStb), .regWrIndex_ff(wrIdx),
        .regWrData_ff(wrDat), .cfgRdIndex(cfgRdIndex), .cfgRdData(cfgRdData));
    lmi_host_model i_lmi_host_model (.clk_sys(clk_sys), .sdaBus(sdaBus), .sclM(sclM),
        .sdaM(sdaM));

    task automatic send(input logic [7:0] v, input logic expAck);
        logic a;
        i_lmi_host_model.wr_byte(v, a);
        `CHK(a, expAck)
    endtask

    task automatic test_write();
        int n0 = stbCount;
        cfgRdIndex = 8'h10;
        i_lmi_host_model.start_cond();
        send(8'ha8, 1'b0);
        send(8'h10, 1'b0);
        `CHK(stbCount, n0)
        send(8'h5a, 1'b0);
        `CHK(stbCount, n0 + 1)
        `CHK(wrIdx, 8'h10)
        `CHK(wrDat, 8'h5a)
        `CHK(sdaOut, 1'b0)
        `CHK(busBusy, 1'b1)
        i_lmi_host_model.stop_cond();
        `CHK(busBusy, 1'b0)
        `CHK(cfgRdData, 8'h5a)
        $display("test write done");
    endtask

    task automatic test_autoinc();
        int n0 = stbCount;
        i_lmi_host_model.start_cond();
        send(8'ha8, 1'b0);
        send(8'h20, 1'b0);
        for (int i = 1; i <= 3; i++)
            send(8'(8'h11 * i), 1'b0);
        `CHK(stbCount, n0 + 3)
        `CHK(wrIdx, 8'h22)
        i_lmi_host_model.stop_cond();
        for (int i = 0; i < 3; i++)
        begin
            cfgRdIndex = 8'(8'h20 + i);
            i_lmi_host_model.wait_q(3);
            `CHK(cfgRdData, 8'h11 * (i + 1))
        end
        $display("test autoinc done");
    endtask

    task automatic test_read();
        logic [7:0] v;
        i_lmi_host_model.start_cond();
        send(8'ha8, 1'b0);
        send(8'h20, 1'b0);
        i_lmi_host_model.start_cond();
        send(8'ha9, 1'b0);
        for (int i = 0; i < 3; i++)
        begin
            i_lmi_host_model.rd_byte(i == 2, v);
            `CHK(v, 8'h11 * (i + 1))
        end
        // a wrong next byte would pull about 33 clocks after the fall, so look later
        i_lmi_host_model.wait_q(50);
        `CHK(sdaOe, 1'b0)
        i_lmi_host_model.stop_cond();
        $display("test read done");
    endtask

    task automatic test_addr();
        int n0 = stbCount;
        cfgRdIndex = 8'h30;
        i_lmi_host_model.start_cond();
        send(8'hac, 1'b1);
        send(8'h30, 1'b1);
        send(8'hff, 1'b1);
        i_lmi_host_model.stop_cond();
        `CHK(stbCount, n0)
        `CHK(cfgRdData, 8'h00)
        addrSelPin = 1'b1;
        i_lmi_host_model.start_cond();
        send(8'ha8, 1'b1);
        i_lmi_host_model.stop_cond();
        i_lmi_host_model.start_cond();
        send(8'haa, 1'b0);
        send(8'h30, 1'b0);
        send(8'h77, 1'b0);
        i_lmi_host_model.stop_cond();
        `CHK(cfgRdData, 8'h77)
        addrSelPin = 1'b0;
        $display("test addr done");
    endtask

    // a start or stop in mid-byte must drop the partial byte
    task automatic test_abort();
        int n0 = stbCount;
        logic r;
        i_lmi_host_model.start_cond();
        send(8'ha8, 1'b0);
        send(8'h31, 1'b0);
        for (int i = 0; i < 4; i++)
            i_lmi_host_model.bit_io(i[0], r);
        i_lmi_host_model.start_cond();
        `CHK(stbCount, n0)
        send(8'ha8, 1'b0);
        send(8'h32, 1'b0);
        for (int i = 0; i < 4; i++)
            i_lmi_host_model.bit_io(i[1], r);
        i_lmi_host_model.stop_cond();
        `CHK(busBusy, 1'b0)
        `CHK(stbCount, n0)
        cfgRdIndex = 8'h31;
        i_lmi_host_model.wait_q(3);
        `CHK(cfgRdData, 8'h00)
        $display("test abort done");
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // main sequence: two cycles of reset, then the scenarios
    initial
    begin
        repeat (2) @(negedge clk_sys);
        reset_n = 1'b1;
        i_lmi_host_model.wait_q(5);
        test_write();
        test_autoinc();
        test_read();
        test_addr();
        test_abort();
        end_of_test();
    end

    // the scenarios need about 60000 cycles
    initial
    begin
        repeat (95000) @(posedge clk_sys);
        err_total++;
        end_of_test();
    end
endmodule
